// [rtl/ddrc_pkg.sv]
// How it works
// - store 8-bit check code per written word
// - code over 64 bits, upper half zero
// - check bits only in 32-bit ECC mode
// - recompute and compare code on reads
// - return corrected data on single-bit error
// - detect multi-bit errors, never correct or scrub
// - ECC sub-word write becomes read-modify-write
// - merge bytes, new code, same location
// - two banks, one active-low enable each
// - banks contiguous from 32-Mbyte aligned base
// - boundary values steer bank enable decode
// - leaf selects from configured address bits
// - densities 128M to 1G, 32M-1G total
// - 64Mx8: 13 row, 11 col, bits 28/27
// - 128Mx8: 14 row, 11 col, bits 29/28
// - 16Mx16: 13 row, 9 col, bits 26/25
// - processor port needs no shared-bus arbitration
// - processor first, bus ports next in turn
// - bursts at most eight words
package ddrc_pkg;

    localparam int NPORT     = 3;
    localparam int PROC_PORT = 0;
    localparam int MAX_BEATS = 8;
    localparam int ROW_W     = 14;
    localparam int COL_W     = 11;
    localparam int GRAN_LSB  = 25; // 32 Mbyte granule
    localparam int GRAN_W    = 7;
    localparam int CODE_POS  = 72;
    localparam logic [3:0] BE_FULL = 4'hf;
    localparam logic [1:0] CE_BANK0 = 2'h2;
    localparam logic [1:0] CE_BANK1 = 2'h1;
    localparam logic [1:0] CE_NONE  = 2'h3;

    // one requester's beat
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
        logic [3:0]  be;
        logic [31:0] wdata;
        logic [2:0]  beats_m1;
    } ddrc_req_t;

    // answer to a requester, one-cycle pulse
    typedef struct packed {
        logic        valid;
        logic [31:0] rdata;
        logic        sbe;
        logic        mbe;
        logic        range_err;
    } ddrc_rsp_t;

    // word command toward the memory pins
    typedef struct packed {
        logic             valid;
        logic             write;
        logic [1:0]       bank_chip_enable_n;
        logic [1:0]       leaf_select;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
        logic [3:0]       byte_mask;
        logic [31:0]      wdata;
        logic [7:0]       ecc_check_bits;
    } ddrc_cmd_t;

    typedef struct packed {
        logic [3:0] row_bits;
        logic [3:0] col_bits;
        logic [4:0] ba1;
        logic [4:0] ba0;
    } ddrc_geom_t;

    typedef enum logic [2:0] {
        DEV_16MX8, DEV_8MX16, DEV_32MX8, DEV_16MX16,
        DEV_64MX8, DEV_32MX16, DEV_128MX8, DEV_64MX16
    } ddrc_dev_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ISSUE, ST_RD_WAIT, ST_RMW_WAIT, ST_GAP
    } ddrc_state_t;

    // device geometry per arrangement
    function automatic ddrc_geom_t dev_geom(input ddrc_dev_t d);
        case (d)
            DEV_16MX8:  return '{4'hc, 4'ha, 5'h1a, 5'h19};
            DEV_8MX16:  return '{4'hc, 4'h9, 5'h19, 5'h18};
            DEV_32MX8:  return '{4'hd, 4'ha, 5'h1b, 5'h1a};
            DEV_16MX16: return '{4'hd, 4'h9, 5'h1a, 5'h19};
            DEV_64MX8:  return '{4'hd, 4'hb, 5'h1c, 5'h1b};
            DEV_32MX16: return '{4'hd, 4'ha, 5'h1b, 5'h1a};
            DEV_128MX8: return '{4'he, 4'hb, 5'h1d, 5'h1c};
            DEV_64MX16: return '{4'he, 4'ha, 5'h1c, 5'h1b};
            default:    return '{4'hc, 4'ha, 5'h1a, 5'h19};
        endcase
    endfunction

    // hamming code over 64 bits plus overall parity
    function automatic logic [7:0] ecc_gen(input logic [63:0] d);
        logic [7:0] c;
        int         di;
        c  = '0;
        di = 0;
        for (int p = 1; p < CODE_POS; p++) begin
            if ((p & (p - 1)) != 0) begin
                for (int b = 0; b < 7; b++) begin
                    if (p[b]) c[b] = c[b] ^ d[di];
                end
                di++;
            end
        end
        c[7] = (^d) ^ (^c[6:0]);
        return c;
    endfunction

    // data bit named by a syndrome
    function automatic logic [63:0] ecc_flip(input logic [6:0] syn);
        logic [63:0] m;
        int          di;
        m  = '0;
        di = 0;
        for (int p = 1; p < CODE_POS; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (p == int'(syn)) m[di] = 1'b1;
                di++;
            end
        end
        return m;
    endfunction

endpackage

// [rtl/ddrc_ecc.sv]
`timescale 1ns/1ps
module ddrc_ecc
(
    // write side
    input  wire logic [31:0] wdata_i,
    output logic      [7:0]  wcheck_o,
    // read side
    input  wire logic [31:0] rdata_i,
    input  wire logic [7:0]  rcheck_i,
    output logic      [31:0] cdata_o,
    output logic             sbe_o,
    output logic             mbe_o
);

    logic [7:0]  rgen;
    logic [6:0]  syn;
    logic        perr;
    logic [63:0] flip;

    // upper half of the code word is zero
    assign wcheck_o = ddrc_pkg::ecc_gen({32'h0, wdata_i});
    assign rgen     = ddrc_pkg::ecc_gen({32'h0, rdata_i});

    // syndrome and overall parity
    assign syn  = rgen[6:0] ^ rcheck_i[6:0];
    assign perr = (^rdata_i) ^ (^rcheck_i);
    assign flip = ddrc_pkg::ecc_flip(syn);

    // odd error with syndrome in live data is correctable
    always_comb
    begin
        sbe_o   = 1'b0;
        mbe_o   = 1'b0;
        cdata_o = rdata_i;
        if (perr && flip[63:32] == 32'h0)
        begin
            sbe_o   = 1'b1;
            cdata_o = rdata_i ^ flip[31:0];
        end
        else if (perr || syn != 7'h0)
        begin
            mbe_o = 1'b1;
        end
    end

endmodule // ddrc_ecc

// [rtl/ddrc_ctrl.sv]
`timescale 1ns/1ps
module ddrc_ctrl
(
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_n_i,
    // configuration
    input  wire logic                    ecc_enable_i,
    input  wire ddrc_pkg::ddrc_dev_t     device_cfg_i,
    input  wire logic [6:0]              sdram_base_reg_i,
    input  wire logic [6:0]              bank0_boundary_reg_i,
    input  wire logic [6:0]              bank1_boundary_reg_i,
    // error status
    input  wire logic                    err_clear_i,
    output logic                         sbe_flag_o,
    output logic                         mbe_flag_o,
    output logic [31:0]                  err_addr_o,
    // requesters, port 0 is the processor port
    input  wire ddrc_pkg::ddrc_req_t [2:0] req_i,
    output ddrc_pkg::ddrc_rsp_t [2:0]    rsp_o,
    // memory pins
    output ddrc_pkg::ddrc_cmd_t          mem_cmd_o,
    input  wire logic                    mem_rd_valid_i,
    input  wire logic [31:0]             mem_rd_data_i,
    input  wire logic [7:0]              mem_rd_check_i
);

    ////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        ddrc_pkg::ddrc_state_t          st;
        logic [1:0]                     port;
        logic                           rr_last;
        logic [2:0]                     beat;
        logic [2:0]                     beats_m1;
        logic [31:0]                    addr;
        logic [3:0]                     be;
        logic [31:0]                    wdata;
        ddrc_pkg::ddrc_cmd_t            cmd;
        ddrc_pkg::ddrc_rsp_t [2:0]      rsp;
        logic [40:0]                    rd_pipe1;
        logic [40:0]                    rd_pipe2;
        logic                           sbe_flag;
        logic                           mbe_flag;
        logic [31:0]                    err_addr;
    } ddrc_core_t;

    ddrc_core_t          s_r;
    ddrc_core_t          s_nxt;
    ddrc_pkg::ddrc_req_t cur;
    ddrc_pkg::ddrc_geom_t geom;
    logic [31:0]         off;
    logic [29:0]         wa;
    logic [29:0]         colv;
    logic [29:0]         rowv;
    logic                in_b0;
    logic                in_b1;
    logic                rd_v;
    logic [31:0]         rd_data;
    logic [7:0]          rd_chk;
    logic [31:0]         merged;
    logic [31:0]         ecc_wdata;
    logic [7:0]          wcheck;
    logic [31:0]         cdata;
    logic                sbe;
    logic                mbe;
    logic                partial;
    logic                ev_sbe;
    logic                ev_mbe;

    ////////////////////////////////////////////////////////////////
    // decode of the granted beat

    // live request of the granted port
    assign cur = req_i[s_r.port];

    // offset from the aligned base
    assign off  = s_r.addr - {sdram_base_reg_i, 25'h0};
    assign geom = ddrc_pkg::dev_geom(device_cfg_i);

    // bank ranges from the boundary values
    assign in_b0 = off[31:ddrc_pkg::GRAN_LSB] < bank0_boundary_reg_i;
    assign in_b1 = !in_b0 && off[31:ddrc_pkg::GRAN_LSB] < bank1_boundary_reg_i;

    // row and column from the word address
    assign wa   = off[31:2];
    assign colv = wa & ((30'h1 << geom.col_bits) - 30'h1);
    assign rowv = (wa >> geom.col_bits) & ((30'h1 << geom.row_bits) - 30'h1);

    // partial write under ECC needs a merge
    assign partial = ecc_enable_i && cur.be != ddrc_pkg::BE_FULL;

    ////////////////////////////////////////////////////////////////
    // read return and check code

    // pin capture after the second stage
    assign rd_v    = s_r.rd_pipe2[40];
    assign rd_chk  = s_r.rd_pipe2[39:32];
    assign rd_data = s_r.rd_pipe2[31:0];

    // new bytes over the corrected old word
    always_comb
    begin
        merged = cdata;
        for (int i = 0; i < 4; i++)
        begin
            if (s_r.be[i]) merged[8*i +: 8] = s_r.wdata[8*i +: 8];
        end
    end

    assign ecc_wdata = (s_r.st == ddrc_pkg::ST_RMW_WAIT) ? merged : cur.wdata;

    ddrc_ecc u_ecc
    (
        .wdata_i  (ecc_wdata),
        .wcheck_o (wcheck),
        .rdata_i  (rd_data),
        .rcheck_i (rd_chk),
        .cdata_o  (cdata),
        .sbe_o    (sbe),
        .mbe_o    (mbe)
    );

    ////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        s_nxt           = s_r;
        s_nxt.cmd.valid = 1'b0;
        s_nxt.rsp       = '0;
        s_nxt.rd_pipe1  = {mem_rd_valid_i, mem_rd_check_i, mem_rd_data_i};
        s_nxt.rd_pipe2  = s_r.rd_pipe1;
        ev_sbe          = 1'b0;
        ev_mbe          = 1'b0;
        case (s_r.st)
            ddrc_pkg::ST_IDLE:
            begin
                // processor first, bus ports alternate
                if (req_i[ddrc_pkg::PROC_PORT].valid)
                begin
                    s_nxt.port = 2'h0;
                    s_nxt.st   = ddrc_pkg::ST_ISSUE;
                end
                else if (req_i[1].valid && (!req_i[2].valid || s_r.rr_last))
                begin
                    s_nxt.port    = 2'h1;
                    s_nxt.rr_last = 1'b0;
                    s_nxt.st      = ddrc_pkg::ST_ISSUE;
                end
                else if (req_i[2].valid)
                begin
                    s_nxt.port    = 2'h2;
                    s_nxt.rr_last = 1'b1;
                    s_nxt.st      = ddrc_pkg::ST_ISSUE;
                end
                s_nxt.beat     = 3'h0;
                s_nxt.beats_m1 = req_i[s_nxt.port].beats_m1;
                s_nxt.addr     = {req_i[s_nxt.port].addr[31:2], 2'h0};
            end
            ddrc_pkg::ST_ISSUE:
            begin
                s_nxt.be    = cur.be;
                s_nxt.wdata = cur.wdata;
                s_nxt.st    = ddrc_pkg::ST_GAP;
                if (!(in_b0 || in_b1))
                begin
                    s_nxt.rsp[s_r.port].valid     = 1'b1;
                    s_nxt.rsp[s_r.port].range_err = 1'b1;
                end
                else
                begin
                    // one enable low per command
                    s_nxt.cmd.valid = 1'b1;
                    s_nxt.cmd.bank_chip_enable_n = in_b0 ? ddrc_pkg::CE_BANK0
                                                         : ddrc_pkg::CE_BANK1;
                    s_nxt.cmd.leaf_select = {off[geom.ba1], off[geom.ba0]};
                    s_nxt.cmd.row   = rowv[ddrc_pkg::ROW_W-1:0];
                    s_nxt.cmd.col   = colv[ddrc_pkg::COL_W-1:0];
                    s_nxt.cmd.write = cur.write && !partial;
                    s_nxt.cmd.wdata = cur.wdata;
                    s_nxt.cmd.byte_mask = ~cur.be;
                    // check lines carry the code only with ECC on
                    s_nxt.cmd.ecc_check_bits = ecc_enable_i ? wcheck : 8'h0;
                    if (cur.write && !partial)
                    begin
                        s_nxt.rsp[s_r.port].valid = 1'b1;
                    end
                    else if (cur.write)
                    begin
                        s_nxt.cmd.byte_mask = 4'h0;
                        s_nxt.st = ddrc_pkg::ST_RMW_WAIT;
                    end
                    else
                    begin
                        s_nxt.cmd.byte_mask = 4'h0;
                        s_nxt.st = ddrc_pkg::ST_RD_WAIT;
                    end
                end
            end
            ddrc_pkg::ST_RD_WAIT:
            begin
                // check before the data goes back
                if (rd_v)
                begin
                    s_nxt.rsp[s_r.port].valid = 1'b1;
                    s_nxt.rsp[s_r.port].rdata = ecc_enable_i ? cdata : rd_data;
                    s_nxt.rsp[s_r.port].sbe = ecc_enable_i && sbe;
                    s_nxt.rsp[s_r.port].mbe = ecc_enable_i && mbe;
                    ev_sbe = ecc_enable_i && sbe;
                    ev_mbe = ecc_enable_i && mbe;
                    s_nxt.st = ddrc_pkg::ST_GAP;
                end
            end
            ddrc_pkg::ST_RMW_WAIT:
            begin
                if (rd_v)
                begin
                    s_nxt.rsp[s_r.port].valid = 1'b1;
                    s_nxt.rsp[s_r.port].sbe   = sbe;
                    s_nxt.rsp[s_r.port].mbe   = mbe;
                    ev_sbe = sbe;
                    ev_mbe = mbe;
                    s_nxt.st = ddrc_pkg::ST_GAP;
                    // a bad word is left as found so it stays visible
                    if (!mbe)
                    begin
                        s_nxt.cmd.valid          = 1'b1;
                        s_nxt.cmd.write          = 1'b1;
                        s_nxt.cmd.wdata          = merged;
                        s_nxt.cmd.byte_mask      = 4'h0;
                        s_nxt.cmd.ecc_check_bits = wcheck;
                    end
                end
            end
            ddrc_pkg::ST_GAP:
            begin
                // requester updates its beat during this cycle
                if (s_r.beat == s_r.beats_m1)
                begin
                    s_nxt.st = ddrc_pkg::ST_IDLE;
                end
                else
                begin
                    s_nxt.beat = s_r.beat + 3'h1;
                    s_nxt.addr = s_r.addr + 32'h4;
                    s_nxt.st   = ddrc_pkg::ST_ISSUE;
                end
            end
            default:
            begin
                s_nxt.st = ddrc_pkg::ST_IDLE;
            end
        endcase
        // sticky flags, a new event beats the clear
        s_nxt.sbe_flag = (s_r.sbe_flag && !err_clear_i) || ev_sbe;
        s_nxt.mbe_flag = (s_r.mbe_flag && !err_clear_i) || ev_mbe;
        if (ev_sbe || ev_mbe)
        begin
            s_nxt.err_addr = s_r.addr;
        end
    end

    ////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            s_r <= '0;
            s_r.cmd.bank_chip_enable_n <= ddrc_pkg::CE_NONE;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state
    assign mem_cmd_o  = s_r.cmd;
    assign rsp_o      = s_r.rsp;
    assign sbe_flag_o = s_r.sbe_flag;
    assign mbe_flag_o = s_r.mbe_flag;
    assign err_addr_o = s_r.err_addr;

    ////////////////////////////////////////////////////////////////
    // checks

    ecc_code_ok_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_r.cmd.valid && s_r.cmd.write && ecc_enable_i |->
        s_r.cmd.ecc_check_bits == ddrc_pkg::ecc_gen({32'h0, s_r.cmd.wdata}))
        else $error("check bits do not match written word");

    no_code_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_r.cmd.valid && !ecc_enable_i && $stable(ecc_enable_i) |->
        s_r.cmd.ecc_check_bits == 8'h0)
        else $error("check bits driven with ECC off");

    rmw_read_first_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_r.st == ddrc_pkg::ST_ISSUE && cur.valid && cur.write && partial &&
        (in_b0 || in_b1) |=> s_r.cmd.valid && !s_r.cmd.write &&
        s_r.st == ddrc_pkg::ST_RMW_WAIT)
        else $error("partial write not started as a read");

    rmw_same_word_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_r.st == ddrc_pkg::ST_RMW_WAIT && rd_v && !mbe |=>
        s_r.cmd.valid && s_r.cmd.write && $stable(s_r.cmd.row) &&
        $stable(s_r.cmd.col) && $stable(s_r.cmd.bank_chip_enable_n))
        else $error("merged word not written to the read location");

    mbe_no_fix_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_r.st == ddrc_pkg::ST_RMW_WAIT && rd_v && mbe |=>
        !s_r.cmd.valid && s_r.mbe_flag)
        else $error("multi-bit word written back or not flagged");

    one_bank_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_r.cmd.valid |-> $onehot(~s_r.cmd.bank_chip_enable_n))
        else $error("not exactly one bank enabled");

    proc_first_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_r.st == ddrc_pkg::ST_IDLE && req_i[0].valid |=>
        s_r.st == ddrc_pkg::ST_ISSUE && s_r.port == 2'h0)
        else $error("processor port not served first");

    burst_end_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_r.st == ddrc_pkg::ST_GAP && s_r.beat == s_r.beats_m1 |=>
        s_r.st == ddrc_pkg::ST_IDLE)
        else $error("burst ran past its last beat");

    flag_set_wins_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_r.rsp[s_r.port].valid && s_r.rsp[s_r.port].sbe |->
        s_r.sbe_flag)
        else $error("single-bit error not flagged");

endmodule // ddrc_ctrl

// [testbench/ddrc_mem_model.sv]
`timescale 1ns/1ps
module ddrc_mem_model
(
    // clock
    input  wire logic                clk_i,
    // command, fault mask and answer delay
    input  wire ddrc_pkg::ddrc_cmd_t cmd_i,
    input  wire logic [31:0]         flip_i,
    input  wire logic [3:0]          lat_i,
    // read return
    output logic                     rd_valid_o,
    output logic [31:0]              rd_data_o,
    output logic [7:0]               rd_check_o
);
    logic [39:0] mem [logic [28:0]];
    logic [28:0] key;
    logic [39:0] w;
    int          cnt = 0;

    initial rd_valid_o = 1'b0;
    initial rd_data_o = 32'h0;
    initial rd_check_o = 8'h0;

    // cell chosen by enable, leaf, row and column
    assign key = {cmd_i.bank_chip_enable_n, cmd_i.leaf_select, cmd_i.row, cmd_i.col};

    // store word with code, answer reads lat_i + 1 cycles after the command
    always @(posedge clk_i)
    begin
        rd_valid_o <= 1'b0;
        rd_data_o  <= ~rd_data_o; // released lines invert every cycle rather than hold stale data
        rd_check_o <= ~rd_check_o;
        if (cnt == 1)
        begin
            rd_valid_o <= 1'b1;
            rd_data_o  <= w[31:0] ^ flip_i; // injected bit faults
            rd_check_o <= w[39:32];
        end
        if (cnt > 0)
            cnt <= cnt - 1;
        if (cmd_i.valid === 1'b1)
        begin
            w = mem.exists(key) ? mem[key] : 40'h0;
            if (cmd_i.write === 1'b1)
            begin
                for (int i = 0; i < 4; i++)
                    if (!cmd_i.byte_mask[i])
                        w[8*i +: 8] = cmd_i.wdata[8*i +: 8];
                mem[key] = {cmd_i.ecc_check_bits, w[31:0]};
            end
            else
                cnt <= lat_i + 1;
        end
    end
endmodule // ddrc_mem_model

// [testbench/testbench.sv]
`timescale 1ns/1ps
module testbench;
    logic                      clk;
    logic                      rst_n;
    logic                      ecc_on;
    ddrc_pkg::ddrc_dev_t       dev;
    logic                      err_clr;
    logic [31:0]               flip;
    logic [3:0]                lat;
    ddrc_pkg::ddrc_req_t [2:0] req;
    ddrc_pkg::ddrc_rsp_t [2:0] rsp;
    ddrc_pkg::ddrc_rsp_t       last;
    ddrc_pkg::ddrc_cmd_t       cmd;
    logic                      sbe_f;
    logic                      mbe_f;
    logic [31:0]               err_a;
    logic                      rd_v;
    logic [31:0]               rd_d;
    logic [7:0]                rd_c;
    logic [31:0]               a;
    logic [31:0]               model [int];
    int                        order [$];
    int                        tab [3][4] = '{'{4, 28, 11, 13}, '{6, 29, 11, 14}, '{3, 26, 9, 13}};
    int                        n_mismatch = 0;
    int                        comparisons = 0;
    int                        n_rd = 0;
    int                        n_wr = 0;
    int                        rd0, wr0, hb, cw, rw;
    bit                        skip = 1'b0;

    ddrc_ctrl ddrc_ctrl_inst
    (
        .clk_i(clk), .rst_n_i(rst_n), .ecc_enable_i(ecc_on), .device_cfg_i(dev),
        .sdram_base_reg_i(7'h01), .bank0_boundary_reg_i(7'h08),
        .bank1_boundary_reg_i(7'h10), .err_clear_i(err_clr), .sbe_flag_o(sbe_f),
        .mbe_flag_o(mbe_f), .err_addr_o(err_a), .req_i(req), .rsp_o(rsp),
        .mem_cmd_o(cmd), .mem_rd_valid_i(rd_v), .mem_rd_data_i(rd_d), .mem_rd_check_i(rd_c)
    );

    ddrc_mem_model ddrc_mem_model_inst
    (
        .clk_i(clk), .cmd_i(cmd), .flip_i(flip), .lat_i(lat),
        .rd_valid_o(rd_v), .rd_data_o(rd_d), .rd_check_o(rd_c)
    );

    // clock
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // count memory commands by kind
    always @(posedge clk)
    begin
        if (cmd.valid === 1'b1 && cmd.write === 1'b1)
            n_wr++;
        else if (cmd.valid === 1'b1)
            n_rd++;
    end

    ////////////////////////////////////////
    task automatic close_out();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one burst on port p; reads compared with the word model
    task automatic xfer(input int p, input logic wr, input logic [31:0] ad,
                        input logic [3:0] be, input int nb);
        int          t;
        int          w;
        logic [31:0] d;
        d = $urandom;
        req[p] <= '{1'b1, wr, ad, be, d, 3'(nb - 1)};
        for (int k = 0; k < nb; k++)
        begin
            t = 0;
            do
            begin
                @(posedge clk);
                t++;
            end
            while (rsp[p].valid !== 1'b1 && t < 60);
            if (rsp[p].valid !== 1'b1)
            begin
                n_mismatch++;
                close_out();
            end
            last = rsp[p];
            order.push_back(p);
            w = int'(ad[31:2]) + k;
            if (!model.exists(w))
                model[w] = 32'h0;
            if (wr)
            begin
                for (int i = 0; i < 4; i++)
                    if (be[i])
                        model[w][8*i +: 8] = d[8*i +: 8];
            end
            else if (!skip)
                check(last.rdata, model[w] ^ (ecc_on ? 32'h0 : flip));
            d = $urandom;
            if (k == nb - 1)
                req[p].valid <= 1'b0;
            else
                req[p].wdata <= d;
        end
        @(posedge clk);
    endtask

    // enable, leaf and row/column of the last command
    task automatic geo(input logic [31:0] ad);
        logic [31:0] o;
        o = ad - 32'h0200_0000;
        check(cmd.bank_chip_enable_n,
              o[31:25] < 7'h08 ? ddrc_pkg::CE_BANK0 : ddrc_pkg::CE_BANK1);
        check(cmd.leaf_select, {o[hb], o[hb-1]});
        check({cmd.row, cmd.col}, {14'(o >> (2 + cw)) & 14'((1 << rw) - 1),
              11'(o >> 2) & 11'((1 << cw) - 1)});
    endtask

    ////////////////////////////////////////
    initial
    begin
        rst_n   = 1'b0;
        ecc_on  = 1'b1;
        dev     = ddrc_pkg::DEV_64MX8;
        err_clr = 1'b0;
        flip    = 32'h0;
        lat     = 4'h0;
        req     = '0;
        void'($urandom(42));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check(cmd.bank_chip_enable_n, ddrc_pkg::CE_NONE);
        // geometry sweep, random words over both banks
        for (int g = 0; g < 3; g++)
        begin
            dev <= ddrc_pkg::ddrc_dev_t'(3'(tab[g][0]));
            hb = tab[g][1];
            cw = tab[g][2];
            rw = tab[g][3];
            repeat (4)
            begin
                a = 32'h0200_0000 + ($urandom & 32'h1fff_fffc);
                lat <= 4'($urandom_range(7));
                xfer(1, 1'b1, a, 4'hf, 1);
                geo(a);
                xfer(2, 1'b0, a, 4'hf, 1);
                geo(a);
            end
        end
        // single then double bit fault, no scrub
        a = 32'h1200_0040;
        xfer(0, 1'b1, a, 4'hf, 1);
        flip <= 32'h0000_0010;
        wr0 = n_wr;
        xfer(0, 1'b0, a, 4'hf, 1);
        check({last.sbe, sbe_f, err_a}, {2'h3, a});
        flip <= 32'h0000_0030;
        skip = 1'b1;
        xfer(0, 1'b0, a, 4'hf, 1);
        check({last.sbe, last.mbe, mbe_f}, 3'h3);
        check(n_wr, wr0);
        err_clr <= 1'b1;
        @(posedge clk);
        err_clr <= 1'b0;
        @(posedge clk);
        check({sbe_f, mbe_f}, 2'h0);
        // byte write through a faulty slow read
        skip = 1'b0;
        flip <= 32'h0100_0000;
        lat  <= 4'h6;
        rd0 = n_rd;
        wr0 = n_wr;
        xfer(2, 1'b1, a, 4'h2, 1);
        check({n_rd - rd0, n_wr - wr0}, {32'h1, 32'h1});
        flip <= 32'h0;
        xfer(2, 1'b0, a, 4'hf, 1);
        // byte write over a double fault: flagged, nothing written back
        flip <= 32'h0300_0000;
        wr0 = n_wr;
        xfer(2, 1'b1, a + 32'h4, 4'h4, 1);
        check({last.mbe, mbe_f, n_wr - wr0}, {2'h3, 32'h0});
        flip <= 32'h0;
        // longest burst ending on the last word of the region
        rd0 = n_rd;
        wr0 = n_wr;
        xfer(1, 1'b1, 32'h21ff_ffe0, 4'hf, 8);
        xfer(1, 1'b0, 32'h21ff_ffe0, 4'hf, 8);
        check({n_rd - rd0, n_wr - wr0}, {32'h8, 32'h8});
        order.delete();
        fork
            xfer(1, 1'b1, 32'h0200_0200, 4'hf, 1);
            xfer(2, 1'b1, 32'h0200_0300, 4'hf, 1);
            xfer(0, 1'b1, 32'h0200_0400, 4'hf, 1);
        join
        check(order[0], 0);
        // just past either end of the region
        skip = 1'b1;
        rd0 = n_rd;
        xfer(1, 1'b0, 32'h2200_0000, 4'hf, 1);
        check(last.range_err, 1'b1);
        xfer(2, 1'b0, 32'h01ff_fffc, 4'hf, 1);
        check({last.range_err, n_rd - rd0}, {1'b1, 32'h0});
        // plain mode: no code, no merge read, raw data
        ecc_on <= 1'b0;
        err_clr <= 1'b1;
        skip = 1'b0;
        flip <= 32'h0000_0001;
        a = 32'h0a00_0000;
        xfer(1, 1'b1, a, 4'hf, 1);
        check(cmd.ecc_check_bits, 8'h0);
        err_clr <= 1'b0;
        rd0 = n_rd;
        xfer(1, 1'b1, a, 4'h1, 1);
        check(n_rd, rd0);
        xfer(1, 1'b0, a, 4'hf, 1);
        check({last.sbe, sbe_f}, 2'h0);
        close_out();
    end
endmodule // testbench
